/* File: core/ses_pkg.sv */
package ses_pkg;
  // Register byte offsets on the AHB-Lite side
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_DQ_LO = 8'h0C;
  localparam logic [7:0] REG_DQ_MID = 8'h10;
  localparam logic [7:0] REG_DQ_HI = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_RD_LO = 8'h1C;
  localparam logic [7:0] REG_RD_MID = 8'h20;
  localparam logic [7:0] REG_RD_HI = 8'h24;
  localparam int ADDR_W = 8;
  // Control and status bit positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_REINIT = 1;
  localparam int CTRL_JTAG = 2;
  localparam int CTRL_DOUBLE = 3;
  localparam int ST_BUSY = 0;
  localparam int ST_RST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_ACK_WAIT = 3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Power-up timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int LOCK_TIME_NS = 500000;
  localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 16;
  localparam logic [15:0] HOLD_SINGLE = 16'h0020;
  localparam logic [15:0] HOLD_DOUBLE = 16'h0040;
  // Engine opcodes on the two low command bits (values arbitrary)
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SEARCH = 2'h2;
  localparam logic [1:0] OP_LEARN = 2'h3;
  // Pin field layout
  localparam int CMD_PIN_W = 11;
  localparam int DQ_W = 72;
  localparam logic [1:0] SRAM_SELECT = 2'h2;
  localparam int DQ_SEL_LO = 19;
  localparam int DQ_ID_LO = 21;
  localparam int DQ_ID_HI = 25;
  localparam int CMD_EXT_SRAM_ADDR_LO = 6;
  localparam int CMD_EXT_SRAM_ADDR_HI = 8;
  localparam int CMD_BURST = 2;
  // Idle cycles between commands
  localparam int GAP_W = 4;
  localparam logic [3:0] GAP_READ = 4'h5;
  localparam logic [3:0] GAP_WRITE = 4'h1;
  localparam logic [3:0] GAP_LEARN = 4'h1;
  localparam logic [3:0] GAP_SRAM_RD = 4'h5;
  localparam logic [3:0] GAP_SRR = 4'h2;
  localparam logic [3:0] SRAM_WR_TAIL = 4'h2;

  typedef enum logic [2:0] {
    K_SEARCH = 3'b000,
    K_READ = 3'b001,
    K_WRITE = 3'b010,
    K_LEARN = 3'b011,
    K_SRAM_RD = 3'b100,
    K_SRAM_WR = 3'b101
  } ses_kind_e;

  typedef enum logic [3:0] {
    S_PWR = 4'b0000,
    S_LOCK = 4'b0001,
    S_HOLD = 4'b0010,
    S_IDLE = 4'b0011,
    S_PRE = 4'b0100,
    S_CYC1 = 4'b0101,
    S_CYC2 = 4'b0110,
    S_TAIL = 4'b0111,
    S_ACK = 4'b1000
  } ses_state_e;

  localparam int CMD_W = 22;
  typedef struct packed {
    logic [2:0] ext_top;
    logic [4:0] casc_id;
    logic [8:0] cmd_hi;
    logic srr_match;
    logic wide;
    logic [2:0] kind;
  } ses_cmd_s;

  localparam int CFG_W = 5;
  typedef struct packed {
    logic [2:0] hold_latency;
    logic [1:0] table_size_sel;
  } ses_cfg_s;
endpackage : ses_pkg

/* File: core/ses_gap_cnt.sv */
// Down-counter of idle cycles; holds at zero
module ses_gap_cnt #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] val,
  output logic [W-1:0] count,
  output logic zero
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (ce) begin
      if (load) begin
        count <= val;
      end else if (count != '0) begin
        count <= count - 1'b1;
      end
    end
  end

  assign zero = (count == '0);
endmodule : ses_gap_cnt

/* File: core/ses_host.sv */
// How it works
// RULE1: SRAM write is two valid write-opcode cycles
// RULE2: SRAM ops put binary 10 on dq[20:19]
// RULE3: Cascade identifier goes on dq[25:21]
// RULE4: First cycle carries top SRAM address on cmd[8:6]
// RULE5: Burst bit cmd[2] stays zero for SRAM write
// RULE6: Keep driving dq in cycles after write
// RULE7: Next command only after cycle 3 ends
// RULE8: Engine emits SRAM write after search latency
// RULE9: Engine write is followed by one idle cycle
// RULE10: Engine read is followed by five idle cycles
// RULE11: SRAM read waits five plus size plus hold
// RULE12: SRAM write is followed by two idle cycles
// RULE13: Learn is followed by one idle cycle
// RULE14: Search one or two cycles, no wait after
// RULE15: Result-register read after search waits two plus size
// RULE16: SRAM op after search waits size or size+hold
// RULE17: Reads block new commands until acknowledge returns
// RULE18: Hold resets low until supplies are steady
// RULE19: Hold reset for lock time after supplies steady
// RULE20: Then 32 or 64 more cycles, then release
// RULE21: Test reset released on good power or held
// RULE22: Phase reference need not toggle during reset
// RULE23: Same hold latency programmed into every engine
// RULE24: Engine search latency follows its table size
// RULE25: Engine acknowledge adds hold latency to it
// RULE26: Idle counter loaded per command blocks command valid
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
module ses_host #(
  parameter int unsigned LOCK_CYCLES = ses_pkg::LOCK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pwr_good,
  input wire logic eng_ack,
  input wire logic [ses_pkg::DQ_W-1:0] eng_dq_i,
  output logic [ses_pkg::DQ_W-1:0] eng_dq_o,
  output logic eng_dq_oe,
  output logic [ses_pkg::CMD_PIN_W-1:0] eng_cmd,
  output logic command_valid,
  output logic eng_rst_n,
  output logic eng_trst_n
);
  ses_pkg::ses_state_e state_q, state_d;
  ses_pkg::ses_cmd_s cmd_q;
  ses_pkg::ses_cfg_s cfg_q;
  ses_pkg::ses_kind_e kind, prev_kind_q;
  logic [ses_pkg::DQ_W-1:0] dq_q, rd_q, dq_word, dq_s1, dq_s2;
  logic [ses_pkg::CMD_PIN_W-1:0] cmd_word;
  logic ack_s1, ack_s2, ack_d, pwr_s1, pwr_s2, ack_rise;
  logic ap_valid_q, ap_write_q, ap_word_q;
  logic [ses_pkg::ADDR_W-1:0] ap_addr_q;
  logic wr_en, go_wr, busy, go_pend_q, reinit_q, refused_q, jtag_q, double_q;
  logic [ses_pkg::RST_CNT_W-1:0] rst_cnt_q, hold_need, lock_need;
  logic gap_load, gap_zero, two_cycle;
  logic [ses_pkg::GAP_W-1:0] gap_val, gap_count, base_gap, pre_gap, tl, hl;

  // Pin synchronisers; only the second stage and the ack edge delay are read by logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ack_s1, ack_s2, ack_d, pwr_s1, pwr_s2} <= '0;
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else if (ce) begin
      ack_s1 <= eng_ack;
      ack_s2 <= ack_s1;
      ack_d <= ack_s2;
      pwr_s1 <= pwr_good;
      pwr_s2 <= pwr_s1;
      dq_s1 <= eng_dq_i;
      dq_s2 <= dq_s1;
    end
  end
  assign ack_rise = ack_s2 && !ack_d;

  // AHB-Lite slave: one wait state per transfer so reads see prior writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_word_q <= 1'b0;
      ap_addr_q <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
    end else if (ce) begin
      if (hsel && hready && htrans[1]) begin
        ap_valid_q <= 1'b1;
        ap_write_q <= hwrite;
        ap_word_q <= (hsize == ses_pkg::HSIZE_WORD);
        ap_addr_q <= haddr[ses_pkg::ADDR_W-1:0];
        hreadyout <= 1'b0;
      end else if (ap_valid_q) begin
        ap_valid_q <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= '0;
        if (!ap_write_q) begin
          case (ap_addr_q)
            ses_pkg::REG_CTRL: hrdata <= 32'({double_q, jtag_q, 2'b00});
            ses_pkg::REG_CFG: hrdata <= 32'(cfg_q);
            ses_pkg::REG_CMD: hrdata <= 32'(cmd_q);
            ses_pkg::REG_DQ_LO: hrdata <= dq_q[31:0];
            ses_pkg::REG_DQ_MID: hrdata <= dq_q[63:32];
            ses_pkg::REG_DQ_HI: hrdata <= 32'(dq_q[71:64]);
            ses_pkg::REG_STATUS: hrdata <= 32'({state_q == ses_pkg::S_ACK, refused_q,
                eng_rst_n, busy});
            ses_pkg::REG_RD_LO: hrdata <= rd_q[31:0];
            ses_pkg::REG_RD_MID: hrdata <= rd_q[63:32];
            ses_pkg::REG_RD_HI: hrdata <= 32'(rd_q[71:64]);
            default: hrdata <= '0;
          endcase
        end
      end
    end
  end

  assign wr_en = ce && ap_valid_q && ap_write_q && ap_word_q;
  assign busy = go_pend_q || (state_q != ses_pkg::S_IDLE);
  assign go_wr = wr_en && (ap_addr_q == ses_pkg::REG_CTRL) && hwdata[ses_pkg::CTRL_GO];

  // Command and data words may not change while a command is in flight
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= '0;
      cfg_q <= '0;
      dq_q <= '0;
      jtag_q <= 1'b0;
      double_q <= 1'b0;
    end else if (wr_en) begin
      case (ap_addr_q)
        ses_pkg::REG_CTRL: begin
          jtag_q <= hwdata[ses_pkg::CTRL_JTAG];
          double_q <= hwdata[ses_pkg::CTRL_DOUBLE];
        end
        ses_pkg::REG_CFG: cfg_q <= ses_pkg::ses_cfg_s'(hwdata[ses_pkg::CFG_W-1:0]); // [RULE23]
        ses_pkg::REG_CMD: if (!busy) cmd_q <= ses_pkg::ses_cmd_s'(hwdata[ses_pkg::CMD_W-1:0]);
        ses_pkg::REG_DQ_LO: if (!busy) dq_q[31:0] <= hwdata;
        ses_pkg::REG_DQ_MID: if (!busy) dq_q[63:32] <= hwdata;
        ses_pkg::REG_DQ_HI: if (!busy) dq_q[71:64] <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Refused flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_pend_q <= 1'b0;
      reinit_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (ce) begin
      if (go_wr && busy) begin
        refused_q <= 1'b1;
      end else if (wr_en && ap_addr_q == ses_pkg::REG_STATUS && hwdata[ses_pkg::ST_REFUSED]) begin
        refused_q <= 1'b0;
      end
      if (go_wr && !busy) begin
        go_pend_q <= 1'b1;
      end else if (state_d == ses_pkg::S_CYC1 || state_d == ses_pkg::S_PRE) begin
        go_pend_q <= 1'b0;
      end
      if (wr_en && ap_addr_q == ses_pkg::REG_CTRL && hwdata[ses_pkg::CTRL_REINIT]) begin
        reinit_q <= 1'b1;
      end else if (state_q == ses_pkg::S_PWR) begin
        reinit_q <= 1'b0;
      end
    end
  end

  assign kind = ses_pkg::ses_kind_e'(cmd_q.kind);
  assign tl = ses_pkg::GAP_W'(cfg_q.table_size_sel);
  assign hl = ses_pkg::GAP_W'(cfg_q.hold_latency);
  assign two_cycle = (kind == ses_pkg::K_WRITE) || (kind == ses_pkg::K_SRAM_WR)
      || (kind == ses_pkg::K_SEARCH && cmd_q.wide); // [RULE14]
  assign lock_need = ses_pkg::RST_CNT_W'(LOCK_CYCLES);
  // No phase reference pin: it may stay still through the whole reset hold
  assign hold_need = double_q ? ses_pkg::HOLD_DOUBLE : ses_pkg::HOLD_SINGLE; // [RULE22]

  // Idle cycles owed after the command just finished
  always_comb begin
    case (kind)
      ses_pkg::K_READ: base_gap = ses_pkg::GAP_READ; // [RULE10]
      ses_pkg::K_WRITE: base_gap = ses_pkg::GAP_WRITE; // [RULE9]
      ses_pkg::K_LEARN: base_gap = ses_pkg::GAP_LEARN; // [RULE13]
      ses_pkg::K_SRAM_RD: base_gap = ses_pkg::GAP_SRAM_RD + tl + hl; // [RULE11]
      default: base_gap = '0;
    endcase
  end

  // Extra wait owed before the next command when the previous one was a search
  always_comb begin
    pre_gap = '0;
    if (prev_kind_q == ses_pkg::K_SEARCH) begin
      case (kind)
        ses_pkg::K_READ: pre_gap = cmd_q.srr_match ? ses_pkg::GAP_SRR + tl : '0; // [RULE15]
        ses_pkg::K_SRAM_RD: pre_gap = tl + hl; // [RULE16]
        ses_pkg::K_SRAM_WR: pre_gap = tl; // [RULE16]
        default: pre_gap = '0;
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    gap_load = 1'b0;
    gap_val = '0;
    case (state_q)
      ses_pkg::S_PWR: if (pwr_s2) state_d = ses_pkg::S_LOCK; // [RULE18]
      ses_pkg::S_LOCK: if (rst_cnt_q == lock_need - 1'b1) state_d = ses_pkg::S_HOLD; // [RULE19]
      ses_pkg::S_HOLD: if (rst_cnt_q == hold_need - 1'b1) state_d = ses_pkg::S_IDLE; // [RULE20]
      ses_pkg::S_IDLE: begin
        if (reinit_q) begin
          state_d = ses_pkg::S_PWR;
        end else if (go_pend_q && gap_zero) begin // [RULE26]
          if (pre_gap != '0) begin
            state_d = ses_pkg::S_PRE;
            gap_load = 1'b1;
            gap_val = pre_gap;
          end else begin
            state_d = ses_pkg::S_CYC1;
          end
        end
      end
      ses_pkg::S_PRE: if (gap_zero) state_d = ses_pkg::S_CYC1;
      ses_pkg::S_CYC1, ses_pkg::S_CYC2: begin
        if (state_q == ses_pkg::S_CYC1 && two_cycle) begin
          state_d = ses_pkg::S_CYC2; // [RULE1]
        end else if (kind == ses_pkg::K_SRAM_WR) begin
          state_d = ses_pkg::S_TAIL; // [RULE12]
          gap_load = 1'b1;
          gap_val = ses_pkg::SRAM_WR_TAIL;
        end else if (kind == ses_pkg::K_READ || kind == ses_pkg::K_SRAM_RD) begin
          state_d = ses_pkg::S_ACK;
        end else begin
          state_d = ses_pkg::S_IDLE;
          gap_load = 1'b1;
          gap_val = base_gap;
        end
      end
      ses_pkg::S_TAIL: if (gap_count == ses_pkg::GAP_W'(1)) state_d = ses_pkg::S_IDLE; // [RULE7]
      ses_pkg::S_ACK: begin
        if (ack_rise) begin // [RULE17]
          state_d = ses_pkg::S_IDLE;
          gap_load = 1'b1;
          gap_val = base_gap;
        end
      end
      default: state_d = ses_pkg::S_PWR;
    endcase
    if (!pwr_s2) begin
      state_d = ses_pkg::S_PWR; // [RULE18]
    end
  end

  ses_gap_cnt #(
    .W(ses_pkg::GAP_W)
  ) u_gap (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .load(gap_load),
    .val(gap_val),
    .count(gap_count),
    .zero(gap_zero)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ses_pkg::S_PWR;
      rst_cnt_q <= '0;
      prev_kind_q <= ses_pkg::K_LEARN;
    end else if (ce) begin
      state_q <= state_d;
      rst_cnt_q <= (state_d != state_q) ? '0 : rst_cnt_q + 1'b1;
      if (state_d == ses_pkg::S_CYC1) prev_kind_q <= kind;
    end
  end

  // Read data taken from the synchronised bus when the acknowledge rises
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= '0;
    end else if (ce && state_q == ses_pkg::S_ACK && ack_rise) begin
      rd_q <= dq_s2;
    end
  end

  // Pin words; SRAM ops steer the address into the SRAM space of one cascade member
  always_comb begin
    dq_word = dq_q;
    cmd_word = {cmd_q.cmd_hi, ses_pkg::OP_SEARCH};
    case (kind)
      ses_pkg::K_READ, ses_pkg::K_SRAM_RD: cmd_word[1:0] = ses_pkg::OP_READ;
      ses_pkg::K_WRITE, ses_pkg::K_SRAM_WR: cmd_word[1:0] = ses_pkg::OP_WRITE; // [RULE1]
      ses_pkg::K_LEARN: cmd_word[1:0] = ses_pkg::OP_LEARN;
      default: ;
    endcase
    if (kind == ses_pkg::K_SRAM_RD || kind == ses_pkg::K_SRAM_WR) begin
      dq_word[ses_pkg::DQ_SEL_LO+1:ses_pkg::DQ_SEL_LO] = ses_pkg::SRAM_SELECT; // [RULE2]
      dq_word[ses_pkg::DQ_ID_HI:ses_pkg::DQ_ID_LO] = cmd_q.casc_id; // [RULE3]
      cmd_word[ses_pkg::CMD_EXT_SRAM_ADDR_HI:ses_pkg::CMD_EXT_SRAM_ADDR_LO] = cmd_q.ext_top; // [RULE4]
    end
    if (kind == ses_pkg::K_SRAM_WR) begin
      cmd_word[ses_pkg::CMD_BURST] = 1'b0; // [RULE5]
    end
  end

  // Valid, command, enable and engine reset pins follow the next state so they line up with state_q
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng_cmd <= '0;
      command_valid <= 1'b0;
      eng_dq_o <= '0;
      eng_dq_oe <= 1'b0;
      eng_rst_n <= 1'b0;
      eng_trst_n <= 1'b0;
    end else if (ce) begin
      command_valid <= (state_d == ses_pkg::S_CYC1) || (state_d == ses_pkg::S_CYC2);
      eng_cmd <= (state_d == ses_pkg::S_CYC1 || state_d == ses_pkg::S_CYC2) ? cmd_word : '0;
      eng_dq_oe <= (state_d == ses_pkg::S_CYC1) || (state_d == ses_pkg::S_CYC2)
          || (state_d == ses_pkg::S_TAIL); // [RULE6]
      eng_dq_o <= dq_word;
      eng_rst_n <= !(state_d == ses_pkg::S_PWR || state_d == ses_pkg::S_LOCK
          || state_d == ses_pkg::S_HOLD); // [RULE20]
      eng_trst_n <= pwr_s2 && jtag_q; // [RULE21]
    end
  end

  sequence s_sram_wr_first;
    ce && state_q == ses_pkg::S_CYC1 && kind == ses_pkg::K_SRAM_WR;
  endsequence
  sequence s_sram_wr_second;
    ce && state_q == ses_pkg::S_CYC2 && kind == ses_pkg::K_SRAM_WR;
  endsequence

  property p_sram_wr_pair;
    @(posedge hclk) disable iff (!hresetn)
    s_sram_wr_first |=> command_valid && eng_cmd[1:0] == ses_pkg::OP_WRITE
        && state_q == ses_pkg::S_CYC2;
  endproperty
  a_sram_wr_pair: assert property (p_sram_wr_pair) else $error("SRAM write too short"); // [RULE1]

  property p_sram_select;
    @(posedge hclk) disable iff (!hresetn)
    command_valid && (kind == ses_pkg::K_SRAM_RD || kind == ses_pkg::K_SRAM_WR)
        |-> eng_dq_o[20:19] == ses_pkg::SRAM_SELECT && eng_dq_o[25:21] == cmd_q.casc_id;
  endproperty
  a_sram_select: assert property (p_sram_select) else $error("SRAM select bits wrong"); // [RULE2]

  property p_casc_id;
    @(posedge hclk) disable iff (!hresetn)
    command_valid && kind == ses_pkg::K_SRAM_WR |-> eng_dq_o[25:21] == cmd_q.casc_id;
  endproperty
  a_casc_id: assert property (p_casc_id) else $error("Cascade id missing on data bus"); // [RULE3]

  property p_ext_sram_addr_top;
    @(posedge hclk) disable iff (!hresetn)
    s_sram_wr_first |-> eng_cmd[8:6] == cmd_q.ext_top && eng_cmd[2] == 1'b0;
  endproperty
  a_ext_sram_addr_top: assert property (p_ext_sram_addr_top) else $error("SRAM top address missing"); // [RULE4]

  property p_no_burst;
    @(posedge hclk) disable iff (!hresetn)
    command_valid && kind == ses_pkg::K_SRAM_WR |-> !eng_cmd[2];
  endproperty
  a_no_burst: assert property (p_no_burst) else $error("Burst bit set on SRAM write"); // [RULE5]

  property p_tail;
    @(posedge hclk) disable iff (!hresetn)
    s_sram_wr_second ##1 ce ##1 ce |-> $past(eng_dq_oe) && eng_dq_oe && !command_valid
        && $past(!command_valid);
  endproperty
  a_tail: assert property (p_tail) else $error("Data bus not held after SRAM write"); // [RULE6]

  property p_write_gap;
    @(posedge hclk) disable iff (!hresetn)
    ce && state_q == ses_pkg::S_CYC2 && kind == ses_pkg::K_WRITE ##1 ce |=> !command_valid;
  endproperty
  a_write_gap: assert property (p_write_gap) else $error("No idle cycle after write"); // [RULE9]

  property p_ack_block;
    @(posedge hclk) disable iff (!hresetn)
    state_q == ses_pkg::S_ACK |-> !command_valid && !eng_dq_oe;
  endproperty
  a_ack_block: assert property (p_ack_block) else $error("Command before ack"); // [RULE17]

  property p_gap_block;
    @(posedge hclk) disable iff (!hresetn)
    ce && state_q == ses_pkg::S_IDLE && !gap_zero |=> !command_valid;
  endproperty
  a_gap_block: assert property (p_gap_block) else $error("Command while gap owed"); // [RULE26]

  property p_rst_hold;
    @(posedge hclk) disable iff (!hresetn)
    ce && $rose(eng_rst_n) |-> $past(state_q) == ses_pkg::S_HOLD
        && $past(rst_cnt_q) == hold_need - 1'b1;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("Engine reset released early"); // [RULE20]
endmodule : ses_host

/* File: tb/ses_eng_model.sv */
module ses_eng_model #(
  parameter logic [4:0] MY_ID = 5'h01,
  parameter logic [71:0] RD_DATA = 72'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] tl,
  input wire logic [2:0] hl,
  input wire logic valid,
  input wire logic [10:0] cmd,
  input wire logic [71:0] dq_o,
  input wire logic oe,
  output logic ack,
  output logic [71:0] dq_i,
  output int errs,
  output logic [7:0] gap
);
  logic f, s, m, ws, blk, ns, rd;
  logic [1:0] op;
  logic [7:0] idle, need, req, lat, lim, t, h;
  assign t = 8'(tl);
  assign h = 8'(hl);
  assign rd = op == ses_pkg::OP_READ;
  assign ns = dq_o[20:19] == 2'b10 && cmd[1:0] inside {ses_pkg::OP_READ, ses_pkg::OP_WRITE};
  // After a search an SRAM op waits so the address bus has one driver
  assign req = !ws ? need : !ns ? 8'h00 : cmd[1:0] == ses_pkg::OP_READ ? t + h : t;
  // Search latency, which also paces SRAM reads and acknowledges
  assign lim = 8'h04 + t + (s ? h : 8'h00);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f <= 1'b0;
      s <= 1'b0;
      ws <= 1'b0;
      blk <= 1'b0;
      idle <= 8'hFF;
      need <= 8'h00;
      ack <= 1'b0;
      dq_i <= '0;
      errs <= 0;
    end else begin
      f <= valid;
      ack <= blk && lat == lim;
      // A released bus shows a changing pattern, never the last value
      dq_i <= (blk && lat + 8'h01 >= lim) ? RD_DATA : ~dq_i;
      idle <= (valid || ack) ? 8'h00 : idle + {7'h0, idle != 8'hFF};
      if (blk) lat <= lat + 8'h01;
      if (blk && lat == lim + 8'h01) blk <= 1'b0;
      if (valid && !f) begin
        if (blk || idle < req) errs <= errs + 1;
        gap <= idle;
        op <= cmd[1:0];
        s <= ns;
        m <= dq_o[25:21] == MY_ID;
        ws <= cmd[1:0] == ses_pkg::OP_SEARCH;
      end
      if (valid && f && (cmd[1:0] != op || (s && dq_o[20:19] != 2'b10))) begin
        errs <= errs + 1;
      end
      if (valid && ns && cmd[1:0] == ses_pkg::OP_WRITE && cmd[2]) errs <= errs + 1;
      // Tail data of an SRAM write is ignored, but the bus must stay driven
      if (!valid && s && op == ses_pkg::OP_WRITE && idle < 8'h02 && !oe) begin
        errs <= errs + 1;
      end
      if (f && !valid) begin
        // Read gaps are counted from the acknowledge
        need <= rd ? 8'h05 + (s ? t + h : 8'h00) : 8'(op != ses_pkg::OP_SEARCH) + 8'(s);
        blk <= rd && (!s || m);
        lat <= 8'h00;
      end
    end
  end
endmodule : ses_eng_model

/* File: tb/tb_search_engine_cmd_sequencer.sv */
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module tb_search_engine_cmd_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] kind; logic wide; logic [1:0] op; logic [1:0] n;} ses_row_s;
  localparam logic [71:0] RDAT = 72'hC3_5A5A_1234_8765_F00D;
  localparam logic [4:0] CID = 5'h0B;
  localparam int LOCK = 20;
  ses_row_s rows [7] = '{
    '{3'h0, 1'b0, ses_pkg::OP_SEARCH, 2'h1}, '{3'h0, 1'b1, ses_pkg::OP_SEARCH, 2'h2},
    '{3'h1, 1'b0, ses_pkg::OP_READ, 2'h1}, '{3'h2, 1'b0, ses_pkg::OP_WRITE, 2'h2},
    '{3'h3, 1'b0, ses_pkg::OP_LEARN, 2'h1}, '{3'h4, 1'b0, ses_pkg::OP_READ, 2'h1},
    '{3'h5, 1'b0, ses_pkg::OP_WRITE, 2'h2}};
  logic [2:0] nk [4] = '{3'h3, 3'h4, 3'h5, 3'h1};
  int need [4] = '{0, 10, 3, 5};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pwr_good = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0] htrans = '0;
  logic hreadyout, hresp, ack, oe, cv, rstn, trstn;
  logic [71:0] dqi, dqo, cdq;
  logic [10:0] cmd, ccmd;
  logic [7:0] gap;
  int errs, num_errors = 0, n_compared = 0, cyc = 0, nv = 0, g0 = 0;

  always #12.5 hclk = ~hclk;

  ses_host #(.LOCK_CYCLES(LOCK)) DUT (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(ses_pkg::HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pwr_good(pwr_good), .eng_ack(ack), .eng_dq_i(dqi), .eng_dq_o(dqo), .eng_dq_oe(oe),
    .eng_cmd(cmd), .command_valid(cv), .eng_rst_n(rstn), .eng_trst_n(trstn));

  ses_eng_model #(.MY_ID(CID), .RD_DATA(RDAT)) ENG (.clk(hclk), .rst_n(rstn), .tl(2'h3),
    .hl(3'h7), .valid(cv), .cmd(cmd), .dq_o(dqo), .oe(oe), .ack(ack), .dq_i(dqi), .errs(errs),
    .gap(gap));

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  always @(posedge hclk) begin
    cyc++;
    if (cv && nv == 0) begin
      ccmd = cmd;
      cdq = dqo;
    end
    if (cv) nv++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic settle();
    do bus(ses_pkg::REG_STATUS, 1'b0, '0); while (r[0] !== 1'b0 || r[3] !== 1'b0 || nv == 0);
  endtask : settle

  task automatic run(input logic [31:0] c);
    @(negedge hclk) nv = 0;
    bus(ses_pkg::REG_CMD, 1'b1, c);
    bus(ses_pkg::REG_CTRL, 1'b1, 32'h0000_000D);
    settle();
  endtask : run

  // Reset release is counted from the call, two cycles of slack below and ten above for sync flops
  task automatic wait_rst(input int lo);
    int n;
    n = 0;
    while (rstn !== 1'b1 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    `CHK(n >= lo - 2 && n <= lo + 10, 1'b1)
  endtask : wait_rst

  initial begin
    repeat (4) @(posedge hclk);
    pwr_good <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK({cv, rstn, trstn, oe, hreadyout, hresp}, 6'b000010)
    hresetn <= 1'b1;
    wait_rst(LOCK + 32);
    bus(ses_pkg::REG_STATUS, 1'b0, '0);
    `CHK({trstn, r[ses_pkg::ST_RST_DONE]}, 2'b01)
    bus(ses_pkg::REG_CTRL, 1'b1, 32'h0000_000E);
    bus(ses_pkg::REG_CTRL, 1'b1, 32'h0000_000C);
    wait_rst(LOCK + 64 - 4);
    `CHK(trstn, 1'b1)
    $display("test power-up done");
    bus(ses_pkg::REG_CFG, 1'b1, 32'h0000_001F);
    bus(ses_pkg::REG_DQ_LO, 1'b1, 32'h0000_1234);
    foreach (rows[i]) begin
      run({10'h0, 3'h5, CID, 9'h000, 1'b0, rows[i].wide, rows[i].kind});
      `CHK(nv, int'(rows[i].n))
      `CHK(ccmd[1:0], rows[i].op)
      if (rows[i].kind[2]) `CHK(cdq[25:19], {CID, ses_pkg::SRAM_SELECT})
      if (rows[i].kind[2]) `CHK({ccmd[8:6], ccmd[2]}, 4'hA)
      if (rows[i].op == ses_pkg::OP_READ) begin
        bus(ses_pkg::REG_RD_LO, 1'b0, '0);
        `CHK(r, RDAT[31:0])
        bus(ses_pkg::REG_RD_MID, 1'b0, '0);
        `CHK(r, RDAT[63:32])
        bus(ses_pkg::REG_RD_HI, 1'b0, '0);
        `CHK(r[7:0], RDAT[71:64])
      end
      $display("test row %0d done", i);
    end
    // Bus time alone exceeds every owed gap, so compare against a search-learn baseline
    for (int j = 0; j < 4; j++) begin
      repeat (16) @(posedge hclk);
      run({10'h0, 3'h5, CID, 9'h000, 5'h00});
      run({10'h0, 3'h5, CID, 9'h000, j == 3, 1'b0, nk[j]});
      if (j == 0) g0 = int'(gap);
      `CHK(int'(gap) >= g0 + need[j], 1'b1)
    end
    $display("test search follow-up done");
    @(negedge hclk) nv = 0;
    bus(ses_pkg::REG_CMD, 1'b1, {10'h0, 3'h5, CID, 9'h000, 5'h04});
    bus(ses_pkg::REG_CTRL, 1'b1, 32'h0000_000D);
    bus(ses_pkg::REG_CTRL, 1'b1, 32'h0000_000D);
    bus(ses_pkg::REG_STATUS, 1'b0, '0);
    `CHK(r[ses_pkg::ST_REFUSED], 1'b1)
    settle();
    `CHK(nv, 1)
    bus(ses_pkg::REG_STATUS, 1'b1, 32'h0000_0004);
    bus(ses_pkg::REG_STATUS, 1'b0, '0);
    `CHK(r[ses_pkg::ST_REFUSED], 1'b0)
    bus(8'h3C, 1'b0, '0);
    `CHK({hresp, r}, 33'h0_0000_0000)
    `CHK(errs, 0)
    $display("test refusal and spacing done");
    report_and_stop();
  end
endmodule : tb_search_engine_cmd_sequencer
